// [logic/fma_i2c_assist.sv]
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none

module fma_i2c_assist
    import fma_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    output logic serial_irq_o
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // ------------------------------------------------------------
    // line synchronisers and edge detection
    // ------------------------------------------------------------
    logic [1:0] scl_meta_r, sda_meta_r;
    logic scl_prev_r, sda_prev_r;

    always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            scl_meta_r <= 2'b11;
            sda_meta_r <= 2'b11;
            scl_prev_r <= 1'b1;
            sda_prev_r <= 1'b1;
        end else begin
            scl_meta_r <= {scl_meta_r[0], scl_i};
            sda_meta_r <= {sda_meta_r[0], sda_i};
            scl_prev_r <= scl_meta_r[1];
            sda_prev_r <= sda_meta_r[1];
        end
    end

    logic scl_s, sda_s, scl_rise, scl_fall, start_ev, stop_ev;
    assign scl_s = scl_meta_r[1];
    assign sda_s = sda_meta_r[1];
    assign scl_rise = scl_s & ~scl_prev_r;
    assign scl_fall = ~scl_s & scl_prev_r;
    assign start_ev = scl_s & scl_prev_r & sda_prev_r & ~sda_s;
    assign stop_ev = scl_s & scl_prev_r & ~sda_prev_r & sda_s;

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0] interrupt_control_r, interrupt_control_nxt, peripheral_irq_flags_one_r, peripheral_irq_flags_one_nxt, peripheral_irq_enables_one_r, peripheral_irq_enables_one_nxt;
    logic [7:0] buf_r, buf_nxt, dir_r, dir_nxt, sadd_r, sadd_nxt;
    logic [7:0] shift_r, shift_nxt;
    fma_ctrl_t ctrl_r, ctrl_nxt;
    fma_stat_t stat_r, stat_nxt;
    fma_state_t state_r, state_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic ack_r, ack_nxt, addressed_r, addressed_nxt;

    logic wr_go, rd_go;
    logic [7:0] wr_idx, rd_idx, wr_byte;
    logic i2c_mode, slave_on, byte_done, addr_match;

    assign wr_idx = s_axi_awaddr_i[IDX_LSB +: 8];
    assign rd_idx = s_axi_araddr_i[IDX_LSB +: 8];
    assign wr_byte = s_axi_wdata_i[7:0];
    assign wr_go = s_axi_awvalid_i & s_axi_wvalid_i & ~s_axi_bvalid_o
        & s_axi_wstrb_i[0];
    assign rd_go = s_axi_arvalid_i & ~s_axi_rvalid_o;

    // master assist works in slave-idle or beside an active slave
    assign slave_on = ctrl_r.port_mode_select == MODE_SLAVE7
        || ctrl_r.port_mode_select == MODE_SLAVE10
        || ctrl_r.port_mode_select == MODE_SLAVE7_SS
        || ctrl_r.port_mode_select == MODE_SLAVE10_SS;
    assign i2c_mode = ctrl_r.enable
        & (slave_on | ctrl_r.port_mode_select == MODE_SLAVE_IDLE);
    assign byte_done = scl_fall & (cnt_r == ACK_SLOT);
    assign addr_match = shift_r[7:1] == sadd_r[7:1];

    always_comb begin
        interrupt_control_nxt = interrupt_control_r;
        peripheral_irq_flags_one_nxt = peripheral_irq_flags_one_r;
        peripheral_irq_enables_one_nxt = peripheral_irq_enables_one_r;
        buf_nxt = buf_r;
        dir_nxt = dir_r;
        sadd_nxt = sadd_r;
        ctrl_nxt = ctrl_r;
        stat_nxt = stat_r;
        shift_nxt = shift_r;
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        ack_nxt = ack_r;
        addressed_nxt = addressed_r;
        // software writes first, so hardware events below win
        if (wr_go) begin
            case (wr_idx)
                IDX_INTERRUPT_CONTROL: interrupt_control_nxt = wr_byte;
                IDX_PERIPH_IRQ_FLAGS: peripheral_irq_flags_one_nxt = wr_byte;
                IDX_PERIPH_IRQ_ENABLES: peripheral_irq_enables_one_nxt = wr_byte;
                IDX_SERIAL_DATA_BUFFER: buf_nxt = wr_byte;
                IDX_PORT_C_DIRECTION: dir_nxt = wr_byte;
                IDX_SLAVE_ADDRESS: sadd_nxt = wr_byte;
                IDX_SERIAL_PORT_CONTROL: ctrl_nxt = fma_ctrl_t'(wr_byte);
                IDX_SERIAL_PORT_STATUS: begin
                    stat_nxt.sample_phase_bit = wr_byte[STAT_SW_LSB + 1];
                    stat_nxt.clock_edge_sel = wr_byte[STAT_SW_LSB];
                end
                default: begin
                end
            endcase
        end
        if (rd_go && rd_idx == IDX_SERIAL_DATA_BUFFER) begin
            stat_nxt.buffer_full = 1'b0;
        end
        // bit and byte tracking
        if (scl_rise && cnt_r < BITS_PER_BYTE) begin
            shift_nxt = {shift_r[6:0], sda_s};
        end
        if (scl_rise && state_r != FMA_IDLE) begin
            cnt_nxt = cnt_r + 4'h1;
        end
        if (scl_fall && cnt_r == BITS_PER_BYTE) begin
            // slave keeps listening even if own master lost the bus
            if (state_r == FMA_ADDR) begin
                ack_nxt = slave_on & addr_match & ~stat_r.buffer_full
                    & ~ctrl_r.overflow;
                addressed_nxt = slave_on & addr_match;
            end else begin
                ack_nxt = addressed_r & ~stat_r.read_not_write
                    & ~stat_r.buffer_full & ~ctrl_r.overflow;
            end
        end
        if (byte_done) begin
            ack_nxt = 1'b0;
            cnt_nxt = 4'h0;
            peripheral_irq_flags_one_nxt[SERIAL_IRQ_BIT] = 1'b1;
            if (stat_r.buffer_full || ctrl_r.overflow) begin
                ctrl_nxt.overflow = 1'b1;
            end else if (state_r == FMA_DATA || addressed_r) begin
                buf_nxt = shift_r;
                stat_nxt.buffer_full = 1'b1;
            end
            if (state_r == FMA_ADDR && addressed_r) begin
                stat_nxt.read_not_write = shift_r[0];
            end
            stat_nxt.data_not_addr = state_r == FMA_DATA;
            state_nxt = FMA_DATA;
        end
        // latest bus condition wins; stop frees the bus
        if (start_ev) begin
            stat_nxt.start_seen = 1'b1;
            stat_nxt.stop_seen = 1'b0;
            peripheral_irq_flags_one_nxt[SERIAL_IRQ_BIT] = 1'b1;
            state_nxt = FMA_ADDR;
            cnt_nxt = 4'h0;
            ack_nxt = 1'b0;
            addressed_nxt = 1'b0;
        end
        if (stop_ev) begin
            stat_nxt.stop_seen = 1'b1;
            stat_nxt.start_seen = 1'b0;
            peripheral_irq_flags_one_nxt[SERIAL_IRQ_BIT] = 1'b1;
            state_nxt = FMA_IDLE;
            cnt_nxt = 4'h0;
            ack_nxt = 1'b0;
            addressed_nxt = 1'b0;
        end
        if (!ctrl_nxt.enable) begin
            stat_nxt.start_seen = 1'b0;
            stat_nxt.stop_seen = 1'b0;
            state_nxt = FMA_IDLE;
            cnt_nxt = 4'h0;
            ack_nxt = 1'b0;
            addressed_nxt = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            interrupt_control_r <= RST_ZERO;
            peripheral_irq_flags_one_r <= RST_ZERO;
            peripheral_irq_enables_one_r <= RST_ZERO;
            buf_r <= RST_ZERO;
            dir_r <= RST_DIRECTION;
            sadd_r <= RST_ZERO;
            ctrl_r <= fma_ctrl_t'(RST_ZERO);
            stat_r <= fma_stat_t'(RST_ZERO);
            shift_r <= RST_ZERO;
            state_r <= FMA_IDLE;
            cnt_r <= 4'h0;
            ack_r <= 1'b0;
            addressed_r <= 1'b0;
        end else begin
            interrupt_control_r <= interrupt_control_nxt;
            peripheral_irq_flags_one_r <= peripheral_irq_flags_one_nxt;
            peripheral_irq_enables_one_r <= peripheral_irq_enables_one_nxt;
            buf_r <= buf_nxt;
            dir_r <= dir_nxt;
            sadd_r <= sadd_nxt;
            ctrl_r <= ctrl_nxt;
            stat_r <= stat_nxt;
            shift_r <= shift_nxt;
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            ack_r <= ack_nxt;
            addressed_r <= addressed_nxt;
        end
    end

    // ------------------------------------------------------------
    // line drive and interrupt
    // ------------------------------------------------------------
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_n_o = ~(i2c_mode & ~dir_r[SCL_DIR_BIT]);
    assign sda_oe_n_o = ~(i2c_mode & (~dir_r[SDA_DIR_BIT] | ack_r));
    assign serial_irq_o = interrupt_control_r[GIE_BIT] & interrupt_control_r[PEIE_BIT]
        & peripheral_irq_enables_one_r[SERIAL_IRQ_BIT] & peripheral_irq_flags_one_r[SERIAL_IRQ_BIT];

    // ------------------------------------------------------------
    // bus answers
    // ------------------------------------------------------------
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [7:0] rdata_r, rdata_nxt;

    always_comb begin
        bvalid_nxt = bvalid_r & ~s_axi_bready_i;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r & ~s_axi_rready_i;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        if (s_axi_awvalid_i && s_axi_wvalid_i && !bvalid_r) begin
            bvalid_nxt = 1'b1;
            case (wr_idx)
                IDX_INTERRUPT_CONTROL, IDX_PERIPH_IRQ_FLAGS,
                IDX_PERIPH_IRQ_ENABLES, IDX_SERIAL_DATA_BUFFER,
                IDX_PORT_C_DIRECTION, IDX_SLAVE_ADDRESS,
                IDX_SERIAL_PORT_CONTROL,
                IDX_SERIAL_PORT_STATUS: bresp_nxt = RESP_OKAY;
                default: bresp_nxt = RESP_SLVERR;
            endcase
        end
        if (rd_go) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = RESP_OKAY;
            case (rd_idx)
                IDX_INTERRUPT_CONTROL: rdata_nxt = interrupt_control_r;
                IDX_PERIPH_IRQ_FLAGS: rdata_nxt = peripheral_irq_flags_one_r;
                IDX_PERIPH_IRQ_ENABLES: rdata_nxt = peripheral_irq_enables_one_r;
                IDX_SERIAL_DATA_BUFFER: rdata_nxt = buf_r;
                IDX_PORT_C_DIRECTION: rdata_nxt = dir_r;
                IDX_SLAVE_ADDRESS: rdata_nxt = sadd_r;
                IDX_SERIAL_PORT_CONTROL: rdata_nxt = ctrl_r;
                IDX_SERIAL_PORT_STATUS: rdata_nxt = stat_r;
                default: begin
                    rdata_nxt = RST_ZERO;
                    rresp_nxt = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= RST_ZERO;
        end else begin
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign s_axi_awready_o = s_axi_awvalid_i & s_axi_wvalid_i & ~bvalid_r;
    assign s_axi_wready_o = s_axi_awready_o;
    assign s_axi_bvalid_o = bvalid_r;
    assign s_axi_bresp_o = bresp_r;
    assign s_axi_arready_o = ~rvalid_r;
    assign s_axi_rvalid_o = rvalid_r;
    assign s_axi_rresp_o = rresp_r;
    assign s_axi_rdata_o = {24'h000000, rdata_r};

endmodule : fma_i2c_assist

`default_nettype wire

// [logic/fma_pkg.sv]
package fma_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0b;
    localparam logic [7:0] IDX_PERIPH_IRQ_FLAGS = 8'h0c;
    localparam logic [7:0] IDX_SERIAL_DATA_BUFFER = 8'h13;
    localparam logic [7:0] IDX_SERIAL_PORT_CONTROL = 8'h14;
    localparam logic [7:0] IDX_PORT_C_DIRECTION = 8'h87;
    localparam logic [7:0] IDX_PERIPH_IRQ_ENABLES = 8'h8c;
    localparam logic [7:0] IDX_SLAVE_ADDRESS = 8'h93;
    localparam logic [7:0] IDX_SERIAL_PORT_STATUS = 8'h94;

    localparam int ADDR_W = 12;
    localparam int IDX_LSB = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_DIRECTION = 8'hff;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int GIE_BIT = 7;
    localparam int PEIE_BIT = 6;
    localparam int SERIAL_IRQ_BIT = 3;
    localparam int SCL_DIR_BIT = 3;
    localparam int SDA_DIR_BIT = 4;
    localparam int STAT_SW_LSB = 6;
    localparam logic [7:0] STAT_SW_MASK = 8'hc0;

    // ------------------------------------------------------------
    // port mode encodings (I2C family)
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_SLAVE7 = 4'h6;
    localparam logic [3:0] MODE_SLAVE10 = 4'h7;
    localparam logic [3:0] MODE_SLAVE_IDLE = 4'hb;
    localparam logic [3:0] MODE_SLAVE7_SS = 4'he;
    localparam logic [3:0] MODE_SLAVE10_SS = 4'hf;

    // ------------------------------------------------------------
    // bit counting and bus answers
    // ------------------------------------------------------------
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] ACK_SLOT = 4'h9;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic wcol;
        logic overflow;
        logic enable;
        logic ckp;
        logic [3:0] port_mode_select;
    } fma_ctrl_t;

    typedef struct packed {
        logic sample_phase_bit;
        logic clock_edge_sel;
        logic data_not_addr;
        logic stop_seen;
        logic start_seen;
        logic read_not_write;
        logic update_addr;
        logic buffer_full;
    } fma_stat_t;

    typedef enum logic [1:0] {
        FMA_IDLE = 2'b00,
        FMA_ADDR = 2'b01,
        FMA_DATA = 2'b10
    } fma_state_t;

endpackage : fma_pkg

// [testbench/fma_bus_peer.sv]
`timescale 1ns/100ps
`default_nettype none
module fma_bus_peer (
    input wire logic scl_oe_n_i,
    input wire logic sda_oe_n_i,
    output logic scl_o,
    output logic sda_o
);
    localparam time HALF = 160ns;
    logic scl_pull = 1'h0;
    logic sda_pull = 1'h0;
    // wired-and with pull-ups
    assign scl_o = scl_oe_n_i & ~scl_pull;
    assign sda_o = sda_oe_n_i & ~sda_pull;
    task automatic start_c;
        #7;
        sda_pull = 1'h1;
        #(HALF);
        scl_pull = 1'h1;
        #(HALF);
    endtask : start_c
    task automatic stop_c;
        sda_pull = 1'h1;
        #(HALF);
        scl_pull = 1'h0;
        #(HALF);
        sda_pull = 1'h0;
        #(HALF);
    endtask : stop_c
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_pull = ~b[i];
            #(HALF);
            scl_pull = 1'h0;
            #(HALF);
            scl_pull = 1'h1;
        end
        sda_pull = 1'h0;
        #(HALF);
        scl_pull = 1'h0;
        #(HALF/2);
        ack = ~sda_o;
        #(HALF/2);
        scl_pull = 1'h1;
    endtask : send_byte
endmodule : fma_bus_peer
`default_nettype wire

// [testbench/fma_i2c_assist_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
module fma_i2c_assist_asserts (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic scl_o,
    input wire logic sda_o,
    input wire logic scl_oe_n_o,
    input wire logic sda_oe_n_o,
    input wire logic serial_irq_o
);
    // ----
    // bus and line checks
    // ----
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    property p_wr_ans;
        s_axi_awvalid_i && s_axi_wvalid_i && s_axi_awready_o
            |=> s_axi_bvalid_o;
    endproperty
    a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
    property p_b_hold;
        s_axi_bvalid_o && !s_axi_bready_i
            |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer lost");
    property p_b_block;
        s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
    endproperty
    a_b_block: assert property (p_b_block) else $error("second write taken");
    property p_rd_ans;
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_r_hold;
        s_axi_rvalid_o && !s_axi_rready_i
            |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer lost");
    property p_r_upper;
        s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0;
    endproperty
    a_r_upper: assert property (p_r_upper) else $error("read upper bits set");
    property p_line_low;
        scl_o == 1'h0 && sda_o == 1'h0;
    endproperty
    a_line_low: assert property (p_line_low) else $error("line drive high");
    property p_rst_quiet;
        $rose(resetn_i) |-> scl_oe_n_o && sda_oe_n_o && !serial_irq_o;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("busy in reset");
endmodule : fma_i2c_assist_asserts
bind fma_i2c_assist fma_i2c_assist_asserts chk_u (.*);
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import fma_pkg::*;
    logic ref_clk_i = 1'h0;
    logic resetn_i = 1'h0;
    logic [ADDR_W-1:0] s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
    logic [31:0] s_axi_wdata_i = '0;
    logic [3:0] s_axi_wstrb_i = '0;
    logic s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0;
    logic s_axi_bready_i = 1'h0, s_axi_arvalid_i = 1'h0;
    logic s_axi_rready_i = 1'h0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
    logic s_axi_arready_o, s_axi_rvalid_o, serial_irq_o;
    logic scl_o, sda_o, scl_oe_n_o, sda_oe_n_o, ack;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic [31:0] s_axi_rdata_o;
    logic [7:0] dv [3] = '{8'he7, 8'hef, 8'hf7};
    wire scl_i;
    wire sda_i;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    fma_i2c_assist dut_u (.*);
    fma_bus_peer peer_u (.scl_oe_n_i(scl_oe_n_o), .sda_oe_n_i(sda_oe_n_o),
        .scl_o(scl_i), .sda_o(sda_i));
    initial forever #20 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc > 20000) begin
            fails++;
            end_sim();
        end
    end
    // ----
    // access and compare tasks
    // ----
    task automatic wr(input logic [7:0] idx, input logic [7:0] d,
        input logic [1:0] r = RESP_OKAY);
        @(posedge ref_clk_i);
        s_axi_awaddr_i <= {2'h0, idx, 2'h0};
        s_axi_wdata_i <= {24'h0, d};
        s_axi_wstrb_i <= 4'hf;
        s_axi_awvalid_i <= 1'h1;
        s_axi_wvalid_i <= 1'h1;
        s_axi_bready_i <= 1'h1;
        do @(posedge ref_clk_i); while (!(s_axi_awready_o && s_axi_wready_o));
        s_axi_awvalid_i <= 1'h0;
        s_axi_wvalid_i <= 1'h0;
        do @(posedge ref_clk_i); while (s_axi_bvalid_o !== 1'h1);
        s_axi_bready_i <= 1'h0;
        chk_reg({32'h0, s_axi_bresp_o}, {32'h0, r});
    endtask : wr
    task automatic chk_reg(input logic [33:0] got, input logic [33:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t reg got %h exp %h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic chk_pin(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t pin got %b exp %b", $time, got, exp);
        end
    endtask : chk_pin
    task automatic rchk(input logic [7:0] idx, input logic [7:0] e,
        input logic [1:0] r, input logic [7:0] m = 8'hff);
        @(posedge ref_clk_i);
        s_axi_araddr_i <= {2'h0, idx, 2'h0};
        s_axi_arvalid_i <= 1'h1;
        s_axi_rready_i <= 1'h1;
        do @(posedge ref_clk_i); while (s_axi_arready_o !== 1'h1);
        s_axi_arvalid_i <= 1'h0;
        do @(posedge ref_clk_i); while (s_axi_rvalid_o !== 1'h1);
        s_axi_rready_i <= 1'h0;
        chk_reg({s_axi_rresp_o, s_axi_rdata_o & {24'hffffff, m}}, {r, 24'h0, e});
    endtask : rchk
    task automatic end_sim;
        $display("checks %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_sim
    // ----
    // main sequence; status phase bits never written
    // ----
    initial begin
        repeat (16) @(posedge ref_clk_i);
        resetn_i <= 1'h1;
        repeat (3) @(posedge ref_clk_i);
        rchk(IDX_PORT_C_DIRECTION, RST_DIRECTION, RESP_OKAY);
        rchk(IDX_SERIAL_PORT_STATUS, RST_ZERO, RESP_OKAY);
        rchk(IDX_PERIPH_IRQ_FLAGS, RST_ZERO, RESP_OKAY);
        rchk(IDX_SERIAL_PORT_CONTROL, RST_ZERO, RESP_OKAY);
        rchk(8'h20, 8'h00, RESP_SLVERR);
        wr(8'h20, 8'h00, RESP_SLVERR);
        wr(IDX_SERIAL_PORT_CONTROL, 8'h2b);
        wr(IDX_INTERRUPT_CONTROL, 8'hc0);
        wr(IDX_PERIPH_IRQ_ENABLES, 8'h08);
        for (int i = 0; i < 3; i++) begin
            wr(IDX_PORT_C_DIRECTION, dv[i]);
            chk_pin(scl_oe_n_o, dv[i][SCL_DIR_BIT]);
            chk_pin(sda_oe_n_o, dv[i][SDA_DIR_BIT]);
        end
        // both lines released, as after a lost arbitration
        wr(IDX_PORT_C_DIRECTION, 8'hff);
        chk_pin(sda_oe_n_o, 1'h1);
        peer_u.start_c();
        repeat (8) @(posedge ref_clk_i);
        rchk(IDX_SERIAL_PORT_STATUS, 8'h08, RESP_OKAY, 8'h18);
        rchk(IDX_PERIPH_IRQ_FLAGS, 8'h08, RESP_OKAY);
        chk_pin(serial_irq_o, 1'h1);
        wr(IDX_PERIPH_IRQ_ENABLES, 8'h00);
        wr(IDX_PERIPH_IRQ_FLAGS, 8'h00);
        wr(IDX_PERIPH_IRQ_ENABLES, 8'h08);
        chk_pin(serial_irq_o, 1'h0);
        peer_u.stop_c();
        repeat (8) @(posedge ref_clk_i);
        chk_pin(serial_irq_o, 1'h1);
        rchk(IDX_SERIAL_PORT_STATUS, 8'h10, RESP_OKAY, 8'h18);
        wr(IDX_PERIPH_IRQ_FLAGS, 8'h00);
        peer_u.start_c();
        wr(IDX_PERIPH_IRQ_FLAGS, 8'h00);
        peer_u.send_byte(8'h55, ack);
        repeat (8) @(posedge ref_clk_i);
        rchk(IDX_PERIPH_IRQ_FLAGS, 8'h08, RESP_OKAY);
        chk_pin(ack, 1'h0);
        wr(IDX_SERIAL_PORT_CONTROL, 8'h0b);
        rchk(IDX_SERIAL_PORT_STATUS, 8'h00, RESP_OKAY, 8'h18);
        peer_u.stop_c();
        repeat (8) @(posedge ref_clk_i);
        rchk(IDX_SERIAL_PORT_STATUS, 8'h00, RESP_OKAY, 8'h18);
        wr(IDX_SLAVE_ADDRESS, 8'ha4);
        wr(IDX_SERIAL_PORT_CONTROL, 8'h26);
        peer_u.start_c();
        peer_u.send_byte(8'ha4, ack);
        chk_pin(ack, 1'h1);
        repeat (8) @(posedge ref_clk_i);
        rchk(IDX_SERIAL_PORT_STATUS, 8'h09, RESP_OKAY, 8'h19);
        rchk(IDX_SERIAL_DATA_BUFFER, 8'ha4, RESP_OKAY);
        rchk(IDX_SERIAL_PORT_STATUS, 8'h08, RESP_OKAY, 8'h19);
        peer_u.stop_c();
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
